// >>> common/st_layer1_regs.vh
// constants for the nt-mode layer-1 activation block
// assumes inclusion by bare name from hw files
`ifndef ST_LAYER1_REGS_VH
`define ST_LAYER1_REGS_VH
// apb byte offsets
`define OFF_CONFIG 12'h000
`define OFF_CMD 12'h004
`define OFF_STATUS 12'h008
`define OFF_IRQ 12'h00c
`define OFF_MASK 12'h010
// config fields
`define CFG_SW_SEL 0
`define CFG_VIOL_EN 1
`define CFG_MF_EN 2
`define CFG_QC_EN 3
`define CFG_RESET 4'h0
// irq bits
`define IRQ_MF 0
`define IRQ_QC 1
`define IRQ_ST 2
`define MASK_RESET 3'h7
// commands
`define C_DR 4'h0
`define C_RES 4'h1
`define C_TM1 4'h2
`define C_TM2 4'h3
`define C_RSY 4'h4
`define C_AR 4'h8
`define C_ARL 4'ha
`define C_AI 4'hc
`define C_AIL 4'he
`define C_DC 4'hf
// indications
`define I_TIM 4'h0
`define I_RSY 4'h4
`define I_AR 4'h8
`define I_CVR 4'hb
`define I_AI 4'hc
`define I_DI 4'hf
// transmit infos
`define X_I0 3'h0
`define X_I2 3'h2
`define X_I3 3'h3
`define X_I4 3'h4
`define X_TM1 3'h5
`define X_TM2 3'h6
// timing
`define CLK_HZ 10000000
`define T8_MS 8
`define T16_MS 16
`define T32_MS 32
`define MF_MS 5
`define LOOP_ZERO_FRAMES 3'h4
`endif

// >>> hw/st_layer1_activation_nt.v
// nt-mode layer-1 activation control with apb registers
// assumes a frame strobe and line-detector inputs from the analog front end
`timescale 1ns/10ps
`include "st_layer1_regs.vh"
module st_layer1_activation_nt #(
    parameter T8_CYC = (`CLK_HZ / 1000) * `T8_MS,
    parameter T16_CYC = (`CLK_HZ / 1000) * `T16_MS,
    parameter T32_CYC = (`CLK_HZ / 1000) * `T32_MS,
    parameter MF_FRAMES = 20
) (
    input wire mclk,
    input wire rst,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    // serial port frame strobe and codes
    input wire frameTick,
    input wire [3:0] cmdIn,
    output reg [3:0] indOut,
    // line receive status (async pins)
    input wire lineInfo0,
    input wire lineInfo3,
    input wire lineSync,
    input wire lineViol,
    input wire [1:0] lineQ,
    // channel data
    input wire [17:0] lineRxData,
    input wire [17:0] portTxData,
    output reg [17:0] portRxData,
    output reg [17:0] lineTxData,
    output reg echoZero,
    output reg [2:0] txInfo,
    output reg loopClose,
    output reg pulseOut,
    output reg pulsePol,
    output reg irqOut
);
    // activation machine states, binary coded
    localparam S_RESET = 4'd0, S_DEACT = 4'd1, S_I0 = 4'd2, S_PEND = 4'd3;
    localparam S_WAIT = 4'd4, S_ACT = 4'd5, S_LFL = 4'd6, S_LFU = 4'd7;
    localparam S_PDEA = 4'd8, S_WDC = 4'd9, S_TM1 = 4'd10, S_TM2 = 4'd11;
    // timer width holds the 32 ms count at the default clock
    localparam TW = 20;
    localparam [TW-1:0] T8 = T8_CYC[TW-1:0];
    localparam [TW-1:0] T16 = T16_CYC[TW-1:0];
    localparam [TW-1:0] T32 = T32_CYC[TW-1:0];
    localparam [4:0] MFN = MF_FRAMES[4:0];

    reg [3:0] config_r; // sw select, viol en, mf en, qc en
    reg [2:0] swInfo_r; // software tx info
    reg [2:0] mask_r; // interrupt mask, 1 masks
    reg [2:0] irq_r; // sticky events
    // activation machine state and its next value
    reg [3:0] state_r;
    reg [3:0] state_nxt;
    reg [3:0] cmd_r; // command latched at frame boundary
    // timers saturate so long waits never wrap
    reg [TW-1:0] tmr_r; // 32 ms / 8 ms supervision
    reg [TW-1:0] i0Tmr_r; // info0 duration counter
    reg [2:0] zeroCnt_r; // loop-back zero frames
    // first-cycle marker for a loop-active command
    reg ailSeen_r;
    reg [4:0] mfCnt_r; // frame within multiframe
    // previous samples for change detection
    reg [1:0] qPrev_r;
    reg [5:0] stsPrev_r;
    // loop 2 closed; drives loopClose and echoZero
    reg loopAct_r;
    // indication to be sent at the next frame
    reg [3:0] codeNxt;
    // three-stage pin synchronisers
    reg [5:0] s1_r, s2_r, s3_r, pin_r;
    wire [5:0] pinRaw = {lineQ, lineViol, lineSync, lineInfo3, lineInfo0};

    // sync stage: a change counts once stages two and three agree
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            s1_r <= 6'h00;
            s2_r <= 6'h00;
            s3_r <= 6'h00;
            pin_r <= 6'h00;
        end else begin
            s1_r <= pinRaw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_r <= (s2_r & s3_r) | (~(s2_r ^ s3_r) & s2_r) |
                     ((s2_r ^ s3_r) & pin_r);
        end
    end
    // filtered levels, one bit per line detector and two for q
    wire rxI0 = pin_r[0];
    wire rxI3 = pin_r[1];
    wire rxSync = pin_r[2];
    wire rxViol = pin_r[3];
    wire [1:0] rxQ = pin_r[5:4];
    // software select freezes the machine in its state
    wire swMode = config_r[`CFG_SW_SEL];

    // apb: zero wait, unmapped reads zero with error
    // writes land at the access edge, reads load at setup
    wire apbAcc = psel & penable;
    wire apbWr = apbAcc & pwrite;
    wire apbRd = apbAcc & ~pwrite;
    wire hit = (paddr == `OFF_CONFIG) | (paddr == `OFF_CMD) |
               (paddr == `OFF_STATUS) | (paddr == `OFF_IRQ) |
               (paddr == `OFF_MASK);
    // no wait states: the register file answers at once
    assign pready = 1'b1;
    assign pslverr = apbAcc & ~hit;
    // status word is the machine state above the filtered pin set
    wire [5:0] rxSts = pin_r;
    wire stsRead = apbRd & (paddr == `OFF_STATUS);
    wire irqRead = apbRd & (paddr == `OFF_IRQ);

    // read mux is registered so prdata is a flop
    always @(posedge mclk or posedge rst) begin
        if (rst)
            prdata <= 32'h00000000;
        else if (psel & ~penable & ~pwrite) begin
            case (paddr)
                `OFF_CONFIG: prdata <= {28'h0000000, config_r};
                `OFF_CMD: prdata <= {29'h00000000, swInfo_r};
                `OFF_STATUS: prdata <= {22'h000000, state_r, rxSts};
                `OFF_IRQ: prdata <= {29'h00000000, irq_r};
                `OFF_MASK: prdata <= {29'h00000000, mask_r};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // software registers
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            config_r <= `CFG_RESET; // internal machine by default
            swInfo_r <= `X_I0;
            mask_r <= `MASK_RESET;
        end else if (apbWr) begin
            if (paddr == `OFF_CONFIG)
                config_r <= pwdata[3:0];
            if (paddr == `OFF_CMD)
                swInfo_r <= pwdata[2:0];
            if (paddr == `OFF_MASK)
                mask_r <= pwdata[2:0];
        end
    end

    // command sampled once per frame
    always @(posedge mclk or posedge rst) begin
        if (rst)
            cmd_r <= `C_DC;
        else if (frameTick)
            cmd_r <= cmdIn;
    end

    // multiframe counter and q-change detect
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            mfCnt_r <= 5'd0;
            qPrev_r <= 2'b00;
            stsPrev_r <= 6'h00;
        end else begin
            if (frameTick)
                mfCnt_r <= (mfCnt_r == MFN - 5'd1) ? 5'd0 : mfCnt_r + 5'd1;
            qPrev_r <= rxQ;
            stsPrev_r <= rxSts;
        end
    end
    // event strobes, mf and qc gated by their enable bits, status change by software select
    wire mfEv = frameTick & (mfCnt_r == MFN - 5'd1) & config_r[`CFG_MF_EN];
    wire qcEv = (rxQ != qPrev_r) & config_r[`CFG_QC_EN];
    wire stEv = swMode & (rxSts != stsPrev_r);

    // sticky events: set wins over read clear
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_r <= 3'b000;
            irqOut <= 1'b0;
        end else begin
            irq_r[`IRQ_MF] <= mfEv | (irq_r[`IRQ_MF] & ~irqRead);
            irq_r[`IRQ_QC] <= qcEv | (irq_r[`IRQ_QC] & ~irqRead);
            // status change, cleared by status read
            irq_r[`IRQ_ST] <= stEv | (irq_r[`IRQ_ST] & ~stsRead);
            // mask acts after the sticky bits, so reads show masked events
            irqOut <= |(irq_r & ~mask_r);
        end
    end

    // next state of the activation machine
    // reset wins over every state, each test command over every state but the other test state
    always @* begin
        state_nxt = state_r;
        if (cmd_r == `C_RES)
            state_nxt = S_RESET;
        else if (cmd_r == `C_TM1 && state_r != S_TM2)
            state_nxt = S_TM1;
        else if (cmd_r == `C_TM2 && state_r != S_TM1)
            state_nxt = S_TM2;
        else if (cmd_r == `C_DR && state_r != S_WDC && state_r != S_PDEA)
            state_nxt = S_PDEA;
        else begin
            case (state_r)
                S_RESET, S_TM1, S_TM2:
                    if (cmd_r == `C_DC)
                        state_nxt = S_DEACT;
                S_DEACT: begin
                    if (rxI0)
                        state_nxt = S_I0;
                    else if (cmd_r == `C_AR || cmd_r == `C_ARL)
                        state_nxt = S_PEND;
                end
                S_I0:
                    if (cmd_r == `C_AR || cmd_r == `C_ARL)
                        state_nxt = S_PEND;
                S_PEND:
                    if (rxI3)
                        state_nxt = S_WAIT;
                S_WAIT, S_LFU:
                    if (cmd_r == `C_AI || cmd_r == `C_AIL)
                        state_nxt = S_ACT;
                S_ACT: begin
                    if (!rxSync)
                        state_nxt = S_LFL;
                    else if (cmd_r == `C_RSY)
                        state_nxt = S_LFU;
                end
                S_LFL:
                    if (rxSync && rxI3)
                        state_nxt = S_ACT;
                S_PDEA:
                    if (i0Tmr_r >= T16 || tmr_r >= T32)
                        state_nxt = S_WDC;
                S_WDC:
                    if (cmd_r == `C_DC)
                        state_nxt = S_DEACT;
                default: state_nxt = S_RESET;
            endcase
        end
    end

    // state, timers and loop control
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_r <= S_RESET;
            tmr_r <= {TW{1'b0}};
            i0Tmr_r <= {TW{1'b0}};
            loopAct_r <= 1'b0;
            zeroCnt_r <= 3'd0;
            ailSeen_r <= 1'b0;
        end else begin
            state_r <= swMode ? state_r : state_nxt;
            tmr_r <= (state_nxt != state_r) ? {TW{1'b0}} :
                     (tmr_r == T32 ? tmr_r : tmr_r + 1'b1);
            i0Tmr_r <= (rxI0 && state_r == S_PDEA) ?
                       (i0Tmr_r == T16 ? i0Tmr_r : i0Tmr_r + 1'b1) :
                       {TW{1'b0}};
            // loop commands close the analog loop
            if (cmd_r == `C_ARL || cmd_r == `C_AIL)
                loopAct_r <= 1'b1;
            else if (state_nxt == S_PDEA || state_nxt == S_RESET ||
                     state_nxt == S_DEACT)
                loopAct_r <= 1'b0;
            // zero frames after loop-active recognised
            // cmd_r changes on the frame strobe itself, so the first
            // cycle of a new loop-active command is marked instead
            ailSeen_r <= (cmd_r == `C_AIL);
            if (cmd_r == `C_AIL && !ailSeen_r)
                zeroCnt_r <= `LOOP_ZERO_FRAMES;
            else if (frameTick && zeroCnt_r != 3'd0)
                zeroCnt_r <= zeroCnt_r - 3'd1;
        end
    end

    // indication code per state
    always @* begin
        case (state_r)
            S_RESET: codeNxt = `I_TIM;
            // deactivated: interim while the 8 ms timer runs
            S_DEACT: codeNxt = (rxI0 || tmr_r < T8) ? `I_TIM : `I_DI;
            S_I0: codeNxt = `I_AR;
            S_PEND, S_WAIT: codeNxt = `I_AR;
            S_ACT: codeNxt = `I_AI;
            S_LFL, S_LFU: codeNxt = `I_RSY;
            S_PDEA: codeNxt = `I_TIM;
            S_WDC: codeNxt = `I_DI;
            default: codeNxt = `I_TIM;
        endcase
        if (rxViol && config_r[`CFG_VIOL_EN])
            codeNxt = `I_CVR;
    end

    // transmit info: software value when the machine is off
    wire [2:0] infoNxt = swMode ? swInfo_r :
        (state_r == S_PEND || state_r == S_WAIT || state_r == S_LFL ||
         state_r == S_LFU) ? `X_I2 :
        (state_r == S_ACT) ? `X_I4 :
        (state_r == S_TM1) ? `X_TM1 :
        (state_r == S_TM2) ? `X_TM2 : `X_I0;
    // channels pass only activated or under the info3 override
    wire pass = swMode ? (swInfo_r == `X_I3) : (state_r == S_ACT);

    // outputs: data path, test pulses and indications
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            indOut <= `I_TIM;
            txInfo <= `X_I0;
            portRxData <= 18'h3ffff;
            lineTxData <= 18'h3ffff;
            echoZero <= 1'b0;
            loopClose <= 1'b0;
            pulseOut <= 1'b0;
            pulsePol <= 1'b0;
        end else begin
            if (frameTick)
                indOut <= codeNxt;
            txInfo <= infoNxt;
            loopClose <= loopAct_r; // same path for b1, b2, d
            echoZero <= loopAct_r;
            // line to port: ones unless transparent; zeros while looping in
            if (zeroCnt_r != 3'd0)
                portRxData <= 18'h00000;
            else if (pass)
                portRxData <= lineRxData;
            else
                portRxData <= 18'h3ffff;
            // port to line: same gating, no zero frames this way
            lineTxData <= pass ? portTxData : 18'h3ffff;
            // single pulse once per frame, polarity flips
            // continuous pulses flip every clock (bit rate scaled)
            if (state_r == S_TM1) begin
                pulseOut <= frameTick;
                if (frameTick)
                    pulsePol <= ~pulsePol;
            end else if (state_r == S_TM2) begin
                pulseOut <= 1'b1;
                pulsePol <= ~pulsePol;
            end else begin
                pulseOut <= 1'b0;
            end
        end
    end
endmodule

// >>> tb/st_layer1_activation_nt_checker.sv
// port assertions for the nt activation block
// assumes it is bound onto st_layer1_activation_nt, one clock mclk
`timescale 1ns/10ps
`include "st_layer1_regs.vh"
module st_layer1_activation_nt_checker (
    input wire mclk,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata,
    input wire frameTick,
    input wire [3:0] indOut,
    input wire [17:0] portRxData,
    input wire echoZero,
    input wire [2:0] txInfo,
    input wire loopClose,
    input wire pulseOut,
    input wire pulsePol
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    wire acc; // apb access phase
    assign acc = psel && penable;
    a_ready_high: assert property (pready) else $error("pready low");
    a_unmapped_err: assert property (acc && paddr > `OFF_MASK |-> pslverr)
        else $error("no error on unmapped access");
    a_mapped_ok: assert property
        (acc && paddr[1:0] == 2'b00 && paddr <= `OFF_MASK |-> !pslverr)
        else $error("error on mapped access");
    a_ind_frame: assert property ($changed(indOut) |-> $past(frameTick))
        else $error("indication moved off frame");
    a_ones_idle: assert property (txInfo == `X_I2 &&
        $past(txInfo) == `X_I2 |-> portRxData == 18'h3ffff)
        else $error("port data not ones");
    a_echo_loop: assert property (loopClose && $past(loopClose)
        |-> echoZero) else $error("echo not zero in loop");
    a_cont_toggle: assert property (txInfo == `X_TM2 &&
        $past(txInfo, 2) == `X_TM2 |-> pulsePol != $past(pulsePol))
        else $error("continuous pulses not alternating");
    a_single_steady: assert property (txInfo == `X_TM1 &&
        $past(txInfo, 2) == `X_TM1 && !$past(frameTick) &&
        !$past(frameTick, 2) |-> $stable(pulsePol))
        else $error("single pulse polarity moved mid frame");
    a_rdata_hold: assert property
        ($changed(prdata) |-> $past(psel && !penable && !pwrite))
        else $error("read data moved outside read setup");
    a_single_pulse: assert property (txInfo == `X_TM1 |->
        pulseOut == $past(frameTick)) else $error("single pulse off frame");
    a_cont_pulse: assert property (txInfo == `X_TM2 |-> pulseOut)
        else $error("continuous pulse missing");
    c_active: cover property (txInfo == `X_I4);
    c_loop: cover property (loopClose);
    c_slverr: cover property (pslverr);
endmodule

// >>> tb/st_layer1_activation_nt_test.sv
// self-checking bench for the nt activation block and its terminal
// assumes the design, the terminal model and the checker compiled before
`timescale 1ns/10ps
`include "st_layer1_regs.vh"
module st_layer1_activation_nt_test;
    typedef struct {logic [3:0] cmd; logic wake; int frames;
        logic [3:0] ind; logic [2:0] tx; logic [1:0] chk; logic loop;} row_t;
    logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q;
    logic pready, pslverr, frameTick = 0, wake = 0, bad = 0, e;
    logic [3:0] cmdIn = `C_RES, indOut;
    logic lineInfo0, lineInfo3, lineSync, lineViol;
    logic [1:0] lineQ;
    logic [17:0] lineRxData, portRxData, lineTxData;
    logic [17:0] portTxData = 18'h1b2d4; // upstream channel bits
    logic echoZero, loopClose, pulseOut, pulsePol, irqOut;
    logic [2:0] txInfo;
    int mismatches = 0, n_compared = 0, fcnt = 0;
    // chk bit0 checks the indication, bit1 the loop
    row_t rows[14] = '{
        '{`C_DC, 0, 12, `I_DI, `X_I0, 3, 0}, '{`C_DC, 1, 3, `I_AR, `X_I0, 3, 0},
        '{`C_AR, 1, 4, 0, `X_I2, 2, 0}, '{`C_AI, 1, 4, `I_AI, `X_I4, 3, 0},
        '{`C_AIL, 1, 6, 0, `X_I4, 2, 1}, '{`C_RSY, 1, 4, 0, `X_I2, 0, 0},
        '{`C_DR, 0, 25, `I_DI, `X_I0, 3, 0}, '{`C_DC, 0, 12, `I_DI, `X_I0, 3, 0},
        '{`C_ARL, 1, 4, 0, `X_I2, 2, 1}, '{`C_RES, 0, 3, `I_TIM, `X_I0, 3, 0},
        '{`C_TM1, 0, 4, 0, `X_TM1, 0, 0}, '{`C_DC, 0, 12, `I_DI, `X_I0, 1, 0},
        '{`C_TM2, 0, 4, 0, `X_TM2, 0, 0}, '{`C_RES, 0, 3, `I_TIM, `X_I0, 1, 0}};
    st_layer1_activation_nt #(.T8_CYC(50), .T16_CYC(100), .T32_CYC(200)) DUT (
        .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .pslverr(pslverr), .prdata(prdata), .frameTick(frameTick),
        .cmdIn(cmdIn), .indOut(indOut), .lineInfo0(lineInfo0),
        .lineInfo3(lineInfo3), .lineSync(lineSync), .lineViol(lineViol),
        .lineQ(lineQ), .lineRxData(lineRxData), .portTxData(portTxData),
        .portRxData(portRxData), .lineTxData(lineTxData),
        .echoZero(echoZero), .txInfo(txInfo), .loopClose(loopClose),
        .pulseOut(pulseOut), .pulsePol(pulsePol), .irqOut(irqOut));
    st_terminal_model term (.mclk(mclk), .rst(rst), .txInfo(txInfo),
        .wake(wake), .bad(bad), .lineInfo0(lineInfo0),
        .lineInfo3(lineInfo3), .lineSync(lineSync), .lineViol(lineViol),
        .lineQ(lineQ), .lineRxData(lineRxData));
    // 10 mhz clock
    initial begin
        forever #50 mclk = ~mclk;
    end
    // one frame strobe every ten clocks keeps the timers short
    always @(posedge mclk) begin
        fcnt <= (fcnt == 9) ? 0 : fcnt + 1;
        frameTick <= (fcnt == 9);
    end
    task check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // one apb transfer; waits an edge first so calls never collide
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge mclk);
        penable <= 1;
        // only the watchdog ends a wait for pready
        do @(posedge mclk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task end_of_test;
        $display("mismatches %0d compared %0d", mismatches, n_compared);
        if (mismatches == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // watchdog against a stuck handshake or state
    initial begin
        repeat (4000) @(posedge mclk);
        mismatches++;
        end_of_test;
    end
    initial begin
        repeat (2) @(posedge mclk);
        rst <= 0;
        #1;
        check("ind", `I_TIM, indOut);
        check("tx", `X_I0, txInfo);
        check("port", 18'h3ffff, portRxData);
        apb(0, `OFF_CONFIG, 0);
        check("cfg", `CFG_RESET, q);
        apb(0, `OFF_MASK, 0);
        check("mask", `MASK_RESET, q);
        apb(0, 12'h020, 0);
        check("err", 1, e);
        check("rd0", 0, q);
        // commands held for whole frames, never two test modes in a row
        foreach (rows[i]) begin
            @(posedge mclk);
            cmdIn <= rows[i].cmd;
            wake <= rows[i].wake;
            repeat (30) @(posedge mclk);
            #1;
            if (rows[i].cmd == `C_AIL)
                check("zero", 0, portRxData);
            repeat (rows[i].frames * 10 - 30) @(posedge mclk);
            #1;
            check("tx", rows[i].tx, txInfo);
            if (rows[i].chk[0])
                check("ind", rows[i].ind, indOut);
            if (rows[i].chk[1])
                check("loop", rows[i].loop, loopClose);
            if (rows[i].tx == `X_I4 && !rows[i].loop) begin
                check("prx", term.PAT, portRxData);
                check("ltx", portTxData, lineTxData);
            end else if (rows[i].tx == `X_I0 || rows[i].tx == `X_I2)
                check("ones", 18'h3ffff, portRxData);
        end
        // software control with the info3 override
        apb(1, `OFF_CONFIG, 32'h1);
        apb(1, `OFF_MASK, 32'h0);
        apb(1, `OFF_CMD, 32'h3);
        apb(0, `OFF_CONFIG, 0);
        check("cfg", 1, q);
        @(posedge mclk);
        wake <= 1;
        repeat (20) @(posedge mclk);
        #1;
        check("swtx", 3'h3, txInfo);
        check("prx", term.PAT, portRxData);
        check("ltx", portTxData, lineTxData);
        check("irq", 1, irqOut);
        apb(0, `OFF_STATUS, 0);
        apb(0, `OFF_IRQ, 0);
        repeat (2) @(posedge mclk);
        #1;
        check("irq", 0, irqOut);
        // q-change and multiframe interrupts with the machine running
        apb(1, `OFF_CONFIG, 32'h1 << `CFG_QC_EN);
        @(posedge mclk);
        wake <= 0; // q bits move
        repeat (12) @(posedge mclk);
        apb(0, `OFF_IRQ, 0);
        check("qirq", 32'h1 << `IRQ_QC, q);
        apb(1, `OFF_CONFIG, 32'h1 << `CFG_MF_EN);
        repeat (210) @(posedge mclk);
        apb(0, `OFF_IRQ, 0); // read inside the multiframe window
        check("mfirq", 32'h1 << `IRQ_MF, q);
        // violations reported only once detection is enabled
        @(posedge mclk);
        bad <= 1;
        repeat (20) @(posedge mclk);
        #1;
        check("noviol", `I_TIM, indOut);
        apb(1, `OFF_CONFIG, 32'h1 << `CFG_VIOL_EN);
        repeat (20) @(posedge mclk);
        #1;
        check("viol", `I_CVR, indOut);
        // reset in mid-run brings outputs and registers back
        @(posedge mclk);
        bad <= 0;
        rst <= 1;
        repeat (2) @(posedge mclk);
        rst <= 0;
        #1;
        check("ind", `I_TIM, indOut);
        check("tx", `X_I0, txInfo);
        check("irq", 0, irqOut);
        apb(0, `OFF_CONFIG, 0);
        check("cfg", `CFG_RESET, q);
        end_of_test;
    end
endmodule
bind st_layer1_activation_nt st_layer1_activation_nt_checker chk (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .frameTick(frameTick), .indOut(indOut),
    .portRxData(portRxData), .echoZero(echoZero), .txInfo(txInfo),
    .loopClose(loopClose), .pulseOut(pulseOut), .pulsePol(pulsePol));

// >>> tb/st_terminal_model.sv
// terminal-side model of the s/t line for the nt activation block
// assumes txInfo codes from st_layer1_regs.vh and one clock mclk
`timescale 1ns/10ps
`include "st_layer1_regs.vh"
module st_terminal_model (
    input wire mclk,
    input wire rst,
    input wire [2:0] txInfo,
    input wire wake,
    input wire bad,
    output reg lineInfo0,
    output reg lineInfo3,
    output reg lineSync,
    output reg lineViol,
    output reg [1:0] lineQ,
    output reg [17:0] lineRxData
);
    localparam [17:0] PAT = 18'h2a5c3; // bits sent while a terminal talks
    wire netTalks; // network side sends info2 or info4
    assign netTalks = (txInfo == `X_I2) || (txInfo == `X_I4);
    // terminal answers info2 with info3 and locks on at once
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            lineInfo0 <= 1'b0;
            lineInfo3 <= 1'b0;
            lineSync <= 1'b0;
            lineViol <= 1'b0;
            lineQ <= 2'b00;
            lineRxData <= 18'h3ffff;
        end else begin
            lineInfo0 <= wake;
            lineInfo3 <= wake && netTalks;
            lineSync <= wake && netTalks;
            lineViol <= bad; // violations on demand
            lineQ <= wake ? 2'b10 : 2'b01; // q moves only with wake
            lineRxData <= wake ? PAT : 18'h3ffff; // silent line reads ones
        end
    end
endmodule
